// ===== pwr_mode_pkg.sv
package pwr_mode_pkg;
    // operating states, one-hot
    typedef enum logic [9:0] {
        ST_HIGH   = 10'h001,
        ST_MED    = 10'h002,
        ST_SLEEP  = 10'h004,
        ST_SUBACT = 10'h008,
        ST_SUBSLP = 10'h010,
        ST_WATCH  = 10'h020,
        ST_SWSTBY = 10'h040,
        ST_HWSTBY = 10'h080,
        ST_POR    = 10'h100,
        ST_MANUAL_RESET_N   = 10'h200
    } mode_t;

    // register byte offsets
    localparam logic [7:0] STANDBY_CTRL_OFS = 8'h00;
    localparam logic [7:0] LOW_POWER_OFS    = 8'h04;
    localparam logic [7:0] MODULE_HALT_OFS  = 8'h08;
    localparam logic [7:0] MODE_STATUS_OFS  = 8'h0c;

    // field positions
    localparam int SOFTWARE_STANDBY_SEL_BIT = 7;
    localparam int DIRECT_TRANSFER_ON_BIT = 7;
    localparam int LOW_SPEED_ON_BIT = 6;
    localparam int PSS_BIT  = 0;
    localparam int DIV_W    = 3;

    // reset values
    localparam logic [7:0] STANDBY_CTRL_RST = 8'h00;
    localparam logic [7:0] LOW_POWER_RST    = 8'h00;
    localparam logic [6:0] MODULE_HALT_RST  = 7'h00;

    // supporting module indices
    localparam int NUM_MOD = 7;
    localparam int M_TMR   = 0;
    localparam int M_TPU   = 1;
    localparam int M_SCI   = 2;
    localparam int M_ADC   = 3;
    localparam int M_DAC   = 4;
    localparam int M_DTC   = 5;
    localparam int M_PBC   = 6;
    // modules whose halt initializes them; others retain
    localparam logic [6:0] RESET_CLASS = 7'h18;
    // modules still running in subactive mode
    localparam logic [6:0] SUBACT_RUN  = 7'h41;

    // wake sources: [0] nmi, [8:1] ext lines, [9] wdog a,
    // [10] wdog b, [11] timer 0, [12] timer 1, [13] any other
    localparam int NUM_SRC = 14;
    localparam logic [13:0] WAKE_ALL   = 14'h3fff;
    localparam logic [13:0] WAKE_TIMED = 14'h1fff;
    localparam logic [13:0] WAKE_PINS  = 14'h01ff;
endpackage

// ===== power_mode_controller.sv
// What this block does
// - reset pin low forces power-on reset state
// - manual reset pin low forces manual reset
// - standby pin low always forces hardware standby
// - wake only on accepted, serviced interrupt
// - each low-power state has its wake-source set
// - sleep or software standby, return prior speed
// - watch entry, wake to high-speed or subactive
// - all four bits set: high-speed to subactive
// - subactive to subsleep or direct high-speed
// - halted-retained modules keep registers, stop work, except TMR and PBC in subactive
// - halted-reset modules initialize registers and state
// - module stop halts only selected modules
// - oscillator off in standby, watch and subclock modes (on in sleep), watchdog on subclock in watch and subclock modes only
// - nonzero divider code selects medium-speed mode
// - halt bit stops module after bus cycle, except in subactive mode, which ignores it
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/1ps
module power_mode_controller (
    // apb
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    // pins
    input  wire logic                power_on_reset_n,
    input  wire logic                manual_reset_n,
    input  wire logic                hw_standby_n,
    // cpu
    input  wire logic                sleep_req,
    input  wire logic                int_accepted,
    input  wire logic                int_nmi,
    input  wire logic [7:0]          ext_int_lines,
    input  wire logic                int_watchdog_a,
    input  wire logic                int_watchdog_b,
    input  wire logic                int_timer0,
    input  wire logic                int_timer1,
    input  wire logic                int_other,
    // power controls
    output pwr_mode_pkg::mode_t      mode,
    output logic                     sysclk_osc_en,
    output logic                     subclk_en,
    output logic                     cpu_run,
    output logic                     cpu_on_subclock,
    output logic [2:0]               bus_master_div,
    output logic                     watchdog_b_on_subclock,
    output logic                     ports_float,
    output logic                     ports_hold,
    output logic [6:0]               module_run,
    output logic [6:0]               module_init
);
    typedef struct packed {
        pwr_mode_pkg::mode_t st;
        logic [2:0]          s1;
        logic [2:0]          s2;
        logic [2:0]          s3;
        logic [2:0]          filt;
        logic [7:0]          sbc;
        logic [7:0]          lpc;
        logic [6:0]          halt;
        logic [31:0]         rdata;
        logic                rdy;
        logic                err;
        logic                osc;
        logic                subclk;
        logic                cpu;
        logic                cpu_sub;
        logic [2:0]          div;
        logic                wdb_sub;
        logic                flt;
        logic                hold;
        logic [6:0]          run;
        logic [6:0]          init;
    } state_t;

    state_t r_ff;
    state_t nxt_r;
    logic [13:0] src;
    logic        wr_acc;

    // per-module run and initialize controls for a mode
    function automatic logic [13:0] mod_ctl(
        input pwr_mode_pkg::mode_t s,
        input logic [6:0]          h
    );
        logic [6:0] run;
        logic [6:0] stop;
        run  = 7'h00;
        stop = 7'h7f;
        case (s)
            pwr_mode_pkg::ST_HIGH,
            pwr_mode_pkg::ST_MED,
            pwr_mode_pkg::ST_SLEEP: begin
                run  = ~h;
                stop = h;
            end
            pwr_mode_pkg::ST_SUBACT: begin
                run  = pwr_mode_pkg::SUBACT_RUN;
                stop = ~pwr_mode_pkg::SUBACT_RUN;
            end
            default: begin
                run  = 7'h00;
                stop = 7'h7f;
            end
        endcase
        // retained class just freezes; reset class initializes
        if (s == pwr_mode_pkg::ST_HWSTBY || s == pwr_mode_pkg::ST_POR
                || s == pwr_mode_pkg::ST_MANUAL_RESET_N) begin
            return {7'h00, 7'h7f};
        end
        return {run, stop & pwr_mode_pkg::RESET_CLASS};
    endfunction

    // wake-source set allowed in each low-power state
    function automatic logic wake_ok(
        input pwr_mode_pkg::mode_t s,
        input logic [13:0]         v
    );
        logic [13:0] m;
        case (s)
            pwr_mode_pkg::ST_SLEEP:  m = pwr_mode_pkg::WAKE_ALL;
            pwr_mode_pkg::ST_WATCH,
            pwr_mode_pkg::ST_SUBSLP: m = pwr_mode_pkg::WAKE_TIMED;
            pwr_mode_pkg::ST_SWSTBY: m = pwr_mode_pkg::WAKE_PINS;
            default:                 m = 14'h0000;
        endcase
        return |(v & m);
    endfunction

    assign src    = {int_other, int_timer1, int_timer0, int_watchdog_b,
                     int_watchdog_a, ext_int_lines, int_nmi};
    assign wr_acc = psel & penable & r_ff.rdy & pwrite;

    // next-state logic
    always_comb begin
        logic software_standby_sel;
        logic subclock_prescaler_sel;
        logic low_speed_on;
        logic direct_transfer_on;
        logic wake;
        logic [13:0] mc;
        // decoded control bits and wake qualifier, set before any use
        software_standby_sel  = r_ff.sbc[pwr_mode_pkg::SOFTWARE_STANDBY_SEL_BIT];
        subclock_prescaler_sel   = r_ff.lpc[pwr_mode_pkg::PSS_BIT];
        low_speed_on  = r_ff.lpc[pwr_mode_pkg::LOW_SPEED_ON_BIT];
        direct_transfer_on  = r_ff.lpc[pwr_mode_pkg::DIRECT_TRANSFER_ON_BIT];
        wake  = int_accepted & wake_ok(r_ff.st, src);
        mc    = 14'h0000;
        nxt_r = r_ff;
        // pin synchronisers, filtered on second and third agreeing
        nxt_r.s1 = {hw_standby_n, manual_reset_n, power_on_reset_n};
        nxt_r.s2 = r_ff.s1;
        nxt_r.s3 = r_ff.s2;
        for (int i = 0; i < 3; i++) begin
            if (r_ff.s2[i] == r_ff.s3[i]) begin
                nxt_r.filt[i] = r_ff.s3[i];
            end
        end
        // apb: setup cycle prepares answer, access cycle commits
        nxt_r.rdy   = psel & ~penable;
        nxt_r.err   = 1'b0;
        nxt_r.rdata = 32'h0000_0000;
        if (psel && !penable) begin
            case (paddr)
                pwr_mode_pkg::STANDBY_CTRL_OFS:
                    nxt_r.rdata = {24'h000000, r_ff.sbc};
                pwr_mode_pkg::LOW_POWER_OFS:
                    nxt_r.rdata = {24'h000000, r_ff.lpc};
                pwr_mode_pkg::MODULE_HALT_OFS:
                    nxt_r.rdata = {25'h0, r_ff.halt};
                pwr_mode_pkg::MODE_STATUS_OFS:
                    nxt_r.rdata = {22'h0, r_ff.st};
                default: nxt_r.err = 1'b1;
            endcase
        end
        if (wr_acc) begin
            case (paddr)
                pwr_mode_pkg::STANDBY_CTRL_OFS:
                    nxt_r.sbc = pwdata[7:0] & 8'h87;
                pwr_mode_pkg::LOW_POWER_OFS:
                    nxt_r.lpc = pwdata[7:0] & 8'hc1;
                pwr_mode_pkg::MODULE_HALT_OFS:
                    nxt_r.halt = pwdata[6:0];
                default: nxt_r.halt = r_ff.halt;
            endcase
        end
        // mode transitions; forbidden combinations leave state as is
        case (r_ff.st)
            pwr_mode_pkg::ST_HIGH, pwr_mode_pkg::ST_MED: begin
                if (sleep_req && !software_standby_sel && !low_speed_on) begin
                    nxt_r.st = pwr_mode_pkg::ST_SLEEP;
                end else if (sleep_req && software_standby_sel && !subclock_prescaler_sel && !low_speed_on) begin
                    nxt_r.st = pwr_mode_pkg::ST_SWSTBY;
                end else if (sleep_req && software_standby_sel && subclock_prescaler_sel && !direct_transfer_on) begin
                    nxt_r.st = pwr_mode_pkg::ST_WATCH;
                end else if (sleep_req && software_standby_sel && subclock_prescaler_sel && low_speed_on && direct_transfer_on
                        && r_ff.st == pwr_mode_pkg::ST_HIGH) begin
                    nxt_r.st = pwr_mode_pkg::ST_SUBACT;
                end else if (nxt_r.sbc[2:0] != 3'h0) begin
                    nxt_r.st = pwr_mode_pkg::ST_MED;
                end else begin
                    nxt_r.st = pwr_mode_pkg::ST_HIGH;
                end
            end
            pwr_mode_pkg::ST_SUBACT: begin
                if (sleep_req && !software_standby_sel && subclock_prescaler_sel && low_speed_on) begin
                    nxt_r.st = pwr_mode_pkg::ST_SUBSLP;
                end else if (sleep_req && software_standby_sel && subclock_prescaler_sel && !direct_transfer_on) begin
                    nxt_r.st = pwr_mode_pkg::ST_WATCH;
                end else if (sleep_req && software_standby_sel && subclock_prescaler_sel && !low_speed_on && direct_transfer_on) begin
                    nxt_r.st = pwr_mode_pkg::ST_HIGH;
                end
            end
            pwr_mode_pkg::ST_SLEEP, pwr_mode_pkg::ST_SWSTBY: begin
                if (wake) begin
                    nxt_r.st = (r_ff.sbc[2:0] != 3'h0) ?
                        pwr_mode_pkg::ST_MED : pwr_mode_pkg::ST_HIGH;
                end
            end
            pwr_mode_pkg::ST_WATCH: begin
                if (wake) begin
                    nxt_r.st = low_speed_on ? pwr_mode_pkg::ST_SUBACT
                                    : pwr_mode_pkg::ST_HIGH;
                end
            end
            pwr_mode_pkg::ST_SUBSLP: begin
                if (wake) begin
                    nxt_r.st = pwr_mode_pkg::ST_SUBACT;
                end
            end
            pwr_mode_pkg::ST_POR, pwr_mode_pkg::ST_MANUAL_RESET_N,
            pwr_mode_pkg::ST_HWSTBY: begin
                nxt_r.st = pwr_mode_pkg::ST_HIGH;
            end
            default: nxt_r.st = pwr_mode_pkg::ST_POR;
        endcase
        // pin-driven states, standby above power-on above manual
        if (!r_ff.filt[2]) begin
            nxt_r.st = pwr_mode_pkg::ST_HWSTBY;
        end else if (r_ff.st == pwr_mode_pkg::ST_HWSTBY) begin
            nxt_r.st = pwr_mode_pkg::ST_POR;
        end else if (!r_ff.filt[0]) begin
            nxt_r.st = pwr_mode_pkg::ST_POR;
        end else if (!r_ff.filt[1] && r_ff.st != pwr_mode_pkg::ST_POR) begin
            nxt_r.st = pwr_mode_pkg::ST_MANUAL_RESET_N;
        end
        // power-on reset and hardware standby clear the control registers; manual reset keeps them
        if (nxt_r.st == pwr_mode_pkg::ST_POR
                || nxt_r.st == pwr_mode_pkg::ST_HWSTBY) begin
            nxt_r.sbc  = pwr_mode_pkg::STANDBY_CTRL_RST;
            nxt_r.lpc  = pwr_mode_pkg::LOW_POWER_RST;
            nxt_r.halt = pwr_mode_pkg::MODULE_HALT_RST;
        end
        // clock and port controls follow the next state
        nxt_r.osc = (nxt_r.st & (pwr_mode_pkg::ST_WATCH
            | pwr_mode_pkg::ST_SUBACT | pwr_mode_pkg::ST_SUBSLP
            | pwr_mode_pkg::ST_SWSTBY | pwr_mode_pkg::ST_HWSTBY)) == 10'h000;
        nxt_r.subclk  = nxt_r.st != pwr_mode_pkg::ST_HWSTBY;
        nxt_r.cpu     = (nxt_r.st & (pwr_mode_pkg::ST_HIGH
            | pwr_mode_pkg::ST_MED | pwr_mode_pkg::ST_SUBACT)) != 10'h000;
        nxt_r.cpu_sub = nxt_r.st == pwr_mode_pkg::ST_SUBACT;
        nxt_r.div     = (nxt_r.st == pwr_mode_pkg::ST_MED) ?
                        nxt_r.sbc[2:0] : 3'h0;
        nxt_r.wdb_sub = (nxt_r.st & (pwr_mode_pkg::ST_WATCH
            | pwr_mode_pkg::ST_SUBACT | pwr_mode_pkg::ST_SUBSLP)) != 10'h000;
        nxt_r.flt     = nxt_r.st == pwr_mode_pkg::ST_HWSTBY;
        nxt_r.hold    = (nxt_r.st == pwr_mode_pkg::ST_WATCH)
                     || (nxt_r.st == pwr_mode_pkg::ST_SWSTBY);
        mc            = mod_ctl(nxt_r.st, nxt_r.halt);
        nxt_r.run     = mc[13:7];
        nxt_r.init    = mc[6:0];
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_ff <= '{st: pwr_mode_pkg::ST_POR, s1: 3'h7, s2: 3'h7,
                      s3: 3'h7, filt: 3'h7, run: 7'h00, init: 7'h7f,
                      default: '0};
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign prdata                 = r_ff.rdata;
    assign pready                 = r_ff.rdy;
    assign pslverr                = r_ff.err & r_ff.rdy;
    assign mode                   = r_ff.st;
    assign sysclk_osc_en          = r_ff.osc;
    assign subclk_en              = r_ff.subclk;
    assign cpu_run                = r_ff.cpu;
    assign cpu_on_subclock        = r_ff.cpu_sub;
    assign bus_master_div         = r_ff.div;
    assign watchdog_b_on_subclock = r_ff.wdb_sub;
    assign ports_float            = r_ff.flt;
    assign ports_hold             = r_ff.hold;
    assign module_run             = r_ff.run;
    assign module_init            = r_ff.init;

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_pins_idle;
        r_ff.filt == 3'h7 && r_ff.st != pwr_mode_pkg::ST_HWSTBY;
    endsequence
    sequence s_div_write;
        wr_acc && paddr == pwr_mode_pkg::STANDBY_CTRL_OFS
            && pwdata[2:0] != 3'h0 && !pwdata[7];
    endsequence

    chk_por_entry: assert property (
        !r_ff.filt[0] && r_ff.filt[2] && r_ff.st != pwr_mode_pkg::ST_HWSTBY
        |=> r_ff.st == pwr_mode_pkg::ST_POR)
        else $error("power-on reset state not entered");
    chk_manual_reset_n_entry: assert property (
        !r_ff.filt[1] && r_ff.filt[0] && r_ff.filt[2]
        && r_ff.st != pwr_mode_pkg::ST_HWSTBY
        && r_ff.st != pwr_mode_pkg::ST_POR
        |=> r_ff.st == pwr_mode_pkg::ST_MANUAL_RESET_N ##0 module_init == 7'h7f)
        else $error("manual reset state not entered");
    chk_hws_entry: assert property (
        !r_ff.filt[2] |=> r_ff.st == pwr_mode_pkg::ST_HWSTBY ##0 ports_float)
        else $error("hardware standby not entered");
    chk_no_bare_wake: assert property (
        s_pins_idle ##0 r_ff.st == pwr_mode_pkg::ST_SLEEP && !int_accepted
        |=> r_ff.st == pwr_mode_pkg::ST_SLEEP)
        else $error("sleep left without accepted interrupt");
    chk_sleep_entry: assert property (
        s_pins_idle ##0 r_ff.st == pwr_mode_pkg::ST_HIGH && sleep_req
        && !r_ff.sbc[pwr_mode_pkg::SOFTWARE_STANDBY_SEL_BIT]
        && !r_ff.lpc[pwr_mode_pkg::LOW_SPEED_ON_BIT]
        |=> r_ff.st == pwr_mode_pkg::ST_SLEEP ##0 !cpu_run)
        else $error("sleep not entered");
    chk_direct_sub: assert property (
        s_pins_idle ##0 r_ff.st == pwr_mode_pkg::ST_HIGH && sleep_req
        && r_ff.sbc[pwr_mode_pkg::SOFTWARE_STANDBY_SEL_BIT] && (r_ff.lpc & 8'hc1) == 8'hc1
        |=> r_ff.st == pwr_mode_pkg::ST_SUBACT ##0 cpu_on_subclock)
        else $error("direct transfer to subactive failed");
    chk_watch_exit: assert property (
        s_pins_idle ##0 r_ff.st == pwr_mode_pkg::ST_WATCH && int_accepted
        && int_nmi && r_ff.lpc[pwr_mode_pkg::LOW_SPEED_ON_BIT]
        |=> r_ff.st == pwr_mode_pkg::ST_SUBACT)
        else $error("watch did not wake to subactive");
    chk_osc_halt: assert property (
        r_ff.st == pwr_mode_pkg::ST_WATCH
        |-> !sysclk_osc_en && watchdog_b_on_subclock && subclk_en)
        else $error("oscillator or subclock wrong in watch");
    chk_med_entry: assert property (
        s_pins_idle ##0 r_ff.st == pwr_mode_pkg::ST_HIGH && !sleep_req
        ##0 s_div_write
        |=> r_ff.st == pwr_mode_pkg::ST_MED
        ##0 bus_master_div == $past(pwdata[2:0]))
        else $error("medium-speed not entered after divider write");
    chk_adc_init: assert property (
        r_ff.st == pwr_mode_pkg::ST_SWSTBY
        |-> module_init[pwr_mode_pkg::M_ADC] && !module_run[pwr_mode_pkg::M_SCI]
        && !module_init[pwr_mode_pkg::M_SCI])
        else $error("standby module controls wrong");
    chk_halt_bit: assert property (
        r_ff.st == pwr_mode_pkg::ST_HIGH |-> module_run == ~r_ff.halt)
        else $error("module halt bit not honoured");
endmodule

// ===== cpu_partner.sv
`timescale 1ns/1ps
module cpu_partner (
    // clock
    input  wire logic        pclk,
    // state seen by the cpu
    input  wire logic [9:0]  mode,
    // to the controller
    output logic             sleep_req,
    output logic             int_accepted,
    output logic [13:0]      src
);
    // quiet at time zero
    initial begin
        sleep_req    = 1'b0;
        int_accepted = 1'b0;
        src          = 14'h0000;
    end

    // one-cycle sleep pulse, issued only while the cpu executes code
    task automatic sleep;
        @(posedge pclk);
        if (mode == 10'h001 || mode == 10'h002 ||
            mode == 10'h008) begin
            sleep_req <= 1'b1;
            @(posedge pclk);
            sleep_req <= 1'b0;
        end
    endtask

    // raise sources, leave them pending, then accept and service
    task automatic wake(input logic [13:0] v, input int pend);
        @(posedge pclk);
        src <= v;
        repeat (pend) @(posedge pclk);
        int_accepted <= 1'b1;
        @(posedge pclk);
        int_accepted <= 1'b0;
        src          <= 14'h0000;
    endtask
endmodule

// ===== tb.sv
`timescale 1ns/1ps
module tb;
    logic                pclk, presetn, psel, penable, pwrite;
    logic [7:0]          paddr;
    logic [31:0]         pwdata, prdata;
    logic                pready, pslverr;
    logic                power_on_reset_n, manual_reset_n, hw_standby_n;
    logic                sleep_req, int_accepted;
    logic [13:0]         src;
    pwr_mode_pkg::mode_t mode;
    logic                sysclk_osc_en, subclk_en, cpu_run, cpu_on_subclock;
    logic                watchdog_b_on_subclock, ports_float, ports_hold;
    logic [2:0]          bus_master_div, div;
    logic [6:0]          module_run, module_init;
    logic [9:0]          exp_mode[$];
    logic [32:0]         exp_rd[$];
    logic [9:0]          last_mode;
    int                  err_total, n_checks, cyc;
    int                  seed = 82833;

    // clock
    initial pclk = 1'b0;
    always #50 pclk = ~pclk;

    power_mode_controller u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .power_on_reset_n(power_on_reset_n),
        .manual_reset_n(manual_reset_n), .hw_standby_n(hw_standby_n),
        .sleep_req(sleep_req), .int_accepted(int_accepted),
        .int_nmi(src[0]), .ext_int_lines(src[8:1]),
        .int_watchdog_a(src[9]), .int_watchdog_b(src[10]),
        .int_timer0(src[11]), .int_timer1(src[12]), .int_other(src[13]),
        .mode(mode), .sysclk_osc_en(sysclk_osc_en), .subclk_en(subclk_en),
        .cpu_run(cpu_run), .cpu_on_subclock(cpu_on_subclock),
        .bus_master_div(bus_master_div),
        .watchdog_b_on_subclock(watchdog_b_on_subclock),
        .ports_float(ports_float), .ports_hold(ports_hold),
        .module_run(module_run), .module_init(module_init)
    );

    cpu_partner u_cpu (
        .pclk(pclk), .mode(mode), .sleep_req(sleep_req),
        .int_accepted(int_accepted), .src(src)
    );

    // compare one value, count it, report a mismatch
    task automatic chk(input string nm, input logic [32:0] seen,
                       input logic [32:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    // one random source bit out of the set m
    function automatic logic [13:0] pick(input logic [13:0] m);
        logic [13:0] v;
        v = 14'h0000;
        while (v == 14'h0000) begin
            v = m & (14'h0001 << (($random(seed) & 32'h7fff) % 14));
        end
        return v;
    endfunction

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (k == 20) chk("pready", 33'h0, 33'h1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic er);
        exp_rd.push_back({er, e});
        apb(1'b0, a, 32'h0);
    endtask

    // wait until every noted mode change has been seen
    task automatic settle;
        int k;
        for (k = 0; k < 40; k++) begin
            if (exp_mode.size() == 0) break;
            @(posedge pclk);
        end
        if (k == 40) chk("mode reached", 33'h0, 33'h1);
        exp_mode.delete();
        repeat (2) @(posedge pclk);
    endtask

    // sleep request expected to land in mode m
    task automatic go(input logic [9:0] m);
        exp_mode.push_back(m);
        u_cpu.sleep();
        settle();
    endtask

    // accepted interrupt expected to return to mode m
    task automatic wk(input logic [9:0] m, input logic [13:0] v);
        exp_mode.push_back(m);
        u_cpu.wake(v, 0);
        settle();
    endtask

    // accepted interrupt from a source outside the wake set
    task automatic ign(input logic [13:0] v);
        u_cpu.wake(v, 0);
        repeat (4) @(posedge pclk);
    endtask

    // watcher: read data and every mode change against the notes
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (exp_rd.size() == 0) chk("read unexpected", 33'h0, 33'h1);
            else chk("read", {pslverr, prdata}, exp_rd.pop_front());
        end
        if (presetn !== 1'b1) last_mode = mode;
        else if (mode !== last_mode) begin
            last_mode = mode;
            if (exp_mode.size() == 0) chk("mode change", 33'h0, 33'h1);
            else chk("mode", mode, exp_mode.pop_front());
        end
    end

    // hang guard
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            end_of_test();
        end
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {power_on_reset_n, manual_reset_n, hw_standby_n} = 3'b111;
        presetn = 1'b0;
        exp_mode.push_back(10'h001);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        settle();
        rd(8'h00, 32'h0, 1'b0);
        rd(8'h04, 32'h0, 1'b0);
        rd(8'h08, 32'h0, 1'b0);
        rd(8'h0c, 32'h001, 1'b0);
        rd(8'h10, 32'h0, 1'b1);
        $display("test reset done");
        div = 3'(((($random(seed) & 32'h7fff) % 5) + 1));
        exp_mode.push_back(10'h002);
        apb(1'b1, 8'h00, {29'h0, div});
        settle();
        chk("divider", bus_master_div, div);
        chk("modules med", module_run, 7'h7f);
        go(10'h004);
        wk(10'h002, pick(14'h3fff));
        exp_mode.push_back(10'h001);
        apb(1'b1, 8'h00, 32'h0);
        settle();
        go(10'h004);
        chk("cpu halted", cpu_run, 1'b0);
        fork
            u_cpu.wake(14'h2000, 6);
            begin
                repeat (5) @(posedge pclk);
                chk("no early wake", mode, 10'h004);
            end
        join
        exp_mode.push_back(10'h001);
        settle();
        $display("test sleep done");
        apb(1'b1, 8'h00, 32'h80);
        go(10'h040);
        chk("osc off", sysclk_osc_en, 1'b0);
        chk("adc init", module_init[3], 1'b1);
        chk("timer kept", module_init[0], 1'b0);
        chk("ports hold", ports_hold, 1'b1);
        ign(pick(14'h3e00));
        wk(10'h001, pick(14'h01ff));
        apb(1'b1, 8'h04, 32'h01);
        go(10'h020);
        chk("wdog b sub", watchdog_b_on_subclock, 1'b1);
        ign(14'h2000);
        wk(10'h001, pick(14'h1fff));
        apb(1'b1, 8'h04, 32'h41);
        go(10'h020);
        wk(10'h008, 14'h0001);
        chk("sub cpu", cpu_on_subclock, 1'b1);
        chk("sub modules", module_run, pwr_mode_pkg::SUBACT_RUN);
        apb(1'b1, 8'h00, 32'h0);
        go(10'h010);
        ign(14'h2000);
        wk(10'h008, pick(14'h1fff));
        apb(1'b1, 8'h00, 32'h80);
        apb(1'b1, 8'h04, 32'h81);
        go(10'h001);
        apb(1'b1, 8'h04, 32'hc1);
        go(10'h008);
        apb(1'b1, 8'h04, 32'h81);
        go(10'h001);
        $display("test low power done");
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h08, 32'h09);
        repeat (2) @(posedge pclk);
        chk("halted run", module_run, 7'h76);
        chk("halted init", module_init, 7'h08);
        exp_mode.push_back(10'h200);
        manual_reset_n <= 1'b0;
        settle();
        exp_mode.push_back(10'h100);
        power_on_reset_n <= 1'b0;
        settle();
        exp_mode.push_back(10'h080);
        hw_standby_n <= 1'b0;
        settle();
        chk("ports float", ports_float, 1'b1);
        chk("subclk off", subclk_en, 1'b0);
        exp_mode.push_back(10'h100);
        exp_mode.push_back(10'h001);
        {power_on_reset_n, manual_reset_n, hw_standby_n} <= 3'b111;
        settle();
        rd(8'h08, 32'h0, 1'b0);
        $display("test pins done");
        end_of_test();
    end
endmodule
